// file: rtl/sfbs_pkg.sv
// package: constants, opcodes, states and state record of the flash boot sequencer
package sfbs_pkg;

  // clock rates in kHz; system clock is 250 MHz
  localparam int CLK_KHZ  = 250000;
  localparam int SLOW_KHZ = 1420;    // first serial clock after reset
  localparam int FAST_KHZ = 30000;   // normal serial clock

  // half periods of the serial clock in system cycles, rounded up so the
  // flash never sees a clock faster than nominal
  localparam logic [7:0] SLOW_HALF = 8'((CLK_KHZ + 2 * SLOW_KHZ - 1) / (2 * SLOW_KHZ));
  localparam logic [7:0] FAST_HALF = 8'((CLK_KHZ + 2 * FAST_KHZ - 1) / (2 * FAST_KHZ));

  // chip select high time between commands
  localparam int CS_HIGH_NS    = 200;
  localparam int CLK_PERIOD_NS = 4;
  localparam logic [7:0] CS_GAP_CYC = 8'((CS_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // flash address width: 24 bits reach 16 MB
  localparam int ADDR_W = 24;

  // command opcodes, always the first byte of a command
  localparam logic [7:0] OPC_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OPC_READ_STATUS  = 8'h05;
  localparam logic [7:0] OPC_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OPC_FAST_READ    = 8'h0B;
  localparam logic [7:0] OPC_PAGE_PROG    = 8'h02;
  localparam logic [7:0] OPC_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OPC_CHIP_ERASE   = 8'hC7;
  localparam logic [7:0] STATUS_CLEAR     = 8'h00;  // write status value, also dummy byte

  // status byte bit positions
  localparam int FLASH_BUSY_FLAG = 0;
  localparam int WRITE_LATCH_BIT = 1;

  // header lengths in bytes (opcode, address, dummy)
  localparam logic [24:0] HDR_ONE   = 25'h0000001;
  localparam logic [24:0] HDR_TWO   = 25'h0000002;
  localparam logic [24:0] HDR_ADDR  = 25'h0000004;
  localparam logic [24:0] HDR_FREAD = 25'h0000005;

  // host command codes
  localparam logic [1:0] OP_READ   = 2'h0;
  localparam logic [1:0] OP_PROG   = 2'h1;
  localparam logic [1:0] OP_SERASE = 2'h2;
  localparam logic [1:0] OP_CERASE = 2'h3;

  // command steps: boot flow first, then host flow
  typedef enum logic [3:0] {
    B_WRITE_ENABLE_CMD, B_WEL, B_WRITE_STATUS_CMD, B_WIP, B_READ,
    H_IDLE, H_WRITE_ENABLE_CMD, H_WEL, H_OP, H_WIP
  } sfbs_step_e;

  // byte engine phases
  typedef enum logic [1:0] {PH_IDLE, PH_GAP, PH_LOAD, PH_SHIFT} sfbs_phase_e;

  // whole state of the sequencer
  typedef struct packed {
    sfbs_step_e        step;
    sfbs_phase_e       phase;
    logic [1:0]        op;
    logic              sel;
    logic              fast;
    logic              boot_done;
    logic              cmd_ready;
    logic              wr_ready;
    logic              sck;
    logic              mosi;
    logic              cs0_n;
    logic              cs1_n;
    logic [7:0]        div;
    logic [2:0]        bitn;
    logic [7:0]        tx;
    logic [7:0]        rx;
    logic [7:0]        status;
    logic [24:0]       k;
    logic [23:0]       len;
    logic [23:0]       addr;
    logic              push;
    logic [7:0]        pdata;
  } sfbs_state_s;

  // state after reset: boot flow at its first write enable, slow clock
  localparam sfbs_state_s SEQ_RESET = '{
    step: B_WRITE_ENABLE_CMD, phase: PH_GAP, op: OP_READ, sel: 1'b0, fast: 1'b0,
    boot_done: 1'b0, cmd_ready: 1'b0, wr_ready: 1'b0, sck: 1'b0, mosi: 1'b0,
    cs0_n: 1'b1, cs1_n: 1'b1, div: 8'h00, bitn: 3'h0, tx: 8'h00, rx: 8'h00,
    status: 8'h00, k: 25'h0000000, len: 24'h000000, addr: 24'h000000,
    push: 1'b0, pdata: 8'h00};

endpackage : sfbs_pkg

// file: rtl/sfbs_stream_if.sv
// interface: valid/ready byte stream between the sequencer and its fifo
`timescale 1ns/1ps
`default_nettype none
interface sfbs_stream_if #(parameter int W = 8);
  logic         valid;  // data offered
  logic         ready;  // data taken when both high
  logic [W-1:0] data;   // payload
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : sfbs_stream_if
`default_nettype wire

// file: rtl/sfbs_fifo.sv
// module: flip-flop fifo with a registered output stage
`timescale 1ns/1ps
`default_nettype none
module sfbs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  // fill and drain sides
  sfbs_stream_if.snk  in_if,
  sfbs_stream_if.src  out_if
);
  localparam int AW = $clog2(DEPTH);

  // entire fifo state; depth must be a power of two for pointer wrap
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic                    iready;
    logic                    ovalid;
    logic [W-1:0]            odata;
  } sfbs_fifo_s;

  sfbs_fifo_s r;    // registered state
  sfbs_fifo_s n;    // next state
  logic       push; // word accepted
  logic       pop;  // output word taken
  logic       load; // memory word moves to output stage

  // next state: write, move to output register, count
  always_comb
  begin
    n    = r;
    push = in_if.valid & r.iready;
    pop  = r.ovalid & out_if.ready;
    load = (r.cnt != '0) & (~r.ovalid | pop);
    if (push)
    begin
      n.mem[r.wp] = in_if.data;
      n.wp        = r.wp + AW'(1);
    end
    if (load)
    begin
      n.odata  = r.mem[r.rp];
      n.rp     = r.rp + AW'(1);
      n.ovalid = 1'b1;
    end
    else if (pop)
    begin
      n.ovalid = 1'b0;
    end
    n.cnt    = r.cnt + (AW + 1)'(push) - (AW + 1)'(load);
    // ready from a flop, so it reflects the count after this cycle
    n.iready = (n.cnt != (AW + 1)'(DEPTH));
  end

  // state register
  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      r        <= '0;
      r.iready <= 1'b1;
    end
    else
    begin
      r <= n;
    end
  end

  assign in_if.ready  = r.iready;
  assign out_if.valid = r.ovalid;
  assign out_if.data  = r.odata;
endmodule : sfbs_fifo
`default_nettype wire

// file: rtl/sfbs_sequencer.sv
// module: serial flash boot sequencer, spi master with two selects and read fifo
`timescale 1ns/1ps
`default_nettype none
module sfbs_sequencer #(
  parameter logic [23:0] BOOT_ADDR  = 24'h000000, // boot image start
  parameter logic [23:0] BOOT_LEN   = 24'h001000, // boot image bytes
  parameter int          FIFO_DEPTH = 16          // read buffer words
) (
  // clock and reset
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  // flash pins
  output logic             O_SPI_SCK,
  output logic             O_SPI_MOSI,
  input  wire logic        I_SPI_MISO,
  output logic             O_BOOT_FLASH_SELECT_N,
  output logic             O_AUX_FLASH_SELECT_N,
  // boot status
  output logic             O_BOOT_DONE,
  output logic             O_FAST_CLK,
  output logic [7:0]       O_STATUS,
  // host commands
  input  wire logic        I_CMD_VALID,
  input  wire logic [1:0]  I_CMD_OP,
  input  wire logic        I_CMD_SEL,
  input  wire logic [23:0] I_CMD_ADDR,
  input  wire logic [23:0] I_CMD_LEN,
  output logic             O_CMD_READY,
  // program data in
  input  wire logic [7:0]  I_WR_DATA,
  input  wire logic        I_WR_VALID,
  output logic             O_WR_READY,
  // read data out (boot image, then host reads)
  output logic [7:0]       O_RD_DATA,
  output logic             O_RD_VALID,
  input  wire logic        I_RD_READY
);

  sfbs_pkg::sfbs_state_s r;  // registered state
  sfbs_pkg::sfbs_state_s n;  // next state
  sfbs_stream_if #(.W(8)) fill_if ();   // sequencer into fifo
  sfbs_stream_if #(.W(8)) drain_if ();  // fifo out to the user
  // decoded view of the current command
  logic [7:0]  half;      // serial clock half period in cycles
  logic [1:0]  eff_op;    // command kind for the op steps
  logic        is_opstep; // step issues a read/program/erase
  logic        has_addr;  // command carries three address bytes
  logic        rd_data;   // data phase reads from the flash
  logic        wr_data;   // data phase writes to the flash
  logic [24:0] hdr;       // bytes before the data phase
  logic [24:0] total;     // bytes in the whole command
  logic        in_data;   // current byte is in the data phase
  logic        last;      // current byte ends the command
  logic [7:0]  opc;       // opcode of the current command
  logic [7:0]  tx_byte;   // byte to shift out next

  // read buffer; its ready stalls the data phase of reads
  sfbs_fifo #(
    .W     (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk  (I_CLK_SYS),
    .i_rst  (I_RST),
    .in_if  (fill_if.snk),
    .out_if (drain_if.src)
  );
  assign fill_if.valid  = r.push;
  assign fill_if.data   = r.pdata;
  assign drain_if.ready = I_RD_READY;
  // command decode
  always_comb
  begin
    // slow rate until protection is cleared, then fast for good
    half      = r.fast ? sfbs_pkg::FAST_HALF : sfbs_pkg::SLOW_HALF;
    is_opstep = (r.step == sfbs_pkg::B_READ) | (r.step == sfbs_pkg::H_OP);
    eff_op    = (r.step == sfbs_pkg::B_READ) ? sfbs_pkg::OP_READ : r.op;
    has_addr  = is_opstep & (eff_op != sfbs_pkg::OP_CERASE);
    rd_data   = is_opstep & (eff_op == sfbs_pkg::OP_READ);
    wr_data   = is_opstep & (eff_op == sfbs_pkg::OP_PROG);
    case (r.step)
      // one opcode plus a single status byte, never a second one
      sfbs_pkg::B_WEL, sfbs_pkg::H_WEL, sfbs_pkg::B_WIP, sfbs_pkg::H_WIP:
      begin
        opc = sfbs_pkg::OPC_READ_STATUS;
        hdr = sfbs_pkg::HDR_TWO;
      end
      sfbs_pkg::B_WRITE_STATUS_CMD:
      begin
        opc = sfbs_pkg::OPC_WRITE_STATUS;
        hdr = sfbs_pkg::HDR_TWO;
      end
      sfbs_pkg::B_READ, sfbs_pkg::H_OP:
      begin
        case (eff_op)
          sfbs_pkg::OP_READ:
          begin
            opc = sfbs_pkg::OPC_FAST_READ;
            hdr = sfbs_pkg::HDR_FREAD;
          end
          sfbs_pkg::OP_PROG:
          begin
            opc = sfbs_pkg::OPC_PAGE_PROG;
            hdr = sfbs_pkg::HDR_ADDR;
          end
          sfbs_pkg::OP_SERASE:
          begin
            opc = sfbs_pkg::OPC_SECTOR_ERASE;
            hdr = sfbs_pkg::HDR_ADDR;
          end
          default:
          begin
            opc = sfbs_pkg::OPC_CHIP_ERASE;
            hdr = sfbs_pkg::HDR_ONE;
          end
        endcase
      end
      default: // write enable steps, and any other step
      begin
        opc = sfbs_pkg::OPC_WRITE_ENABLE;
        hdr = sfbs_pkg::HDR_ONE;
      end
    endcase
    // data phase streams on with one address; the flash increments it
    total   = hdr + ((rd_data | wr_data) ? {1'b0, r.len} : 25'h0000000);
    in_data = (rd_data | wr_data) & (r.k >= hdr);
    last    = (r.k == total - 25'h0000001);
    // byte to send at index k
    if (r.k == 25'h0000000)
    begin
      tx_byte = opc;
    end
    else if (in_data)
    begin
      tx_byte = wr_data ? I_WR_DATA : sfbs_pkg::STATUS_CLEAR;
    end
    else if (has_addr & (r.k <= 25'h0000003))
    begin
      // 24 address bits reach the whole 16 MB, most significant first
      case (r.k[1:0])
        2'h1:    tx_byte = r.addr[23:16];
        2'h2:    tx_byte = r.addr[15:8];
        default: tx_byte = r.addr[7:0];
      endcase
    end
    else
    begin
      // dummy byte of a read, or all eight status bits written to zero
      tx_byte = sfbs_pkg::STATUS_CLEAR;
    end
  end

  // sequencer and byte engine
  always_comb
  begin
    n      = r;
    n.push = 1'b0;
    case (r.phase)
      // idle: accept one host command, selects high
      sfbs_pkg::PH_IDLE:
      begin
        if (r.cmd_ready & I_CMD_VALID)
        begin
          n.cmd_ready = 1'b0;
          n.op        = I_CMD_OP;
          n.sel       = I_CMD_SEL;
          n.addr      = I_CMD_ADDR;
          n.len       = I_CMD_LEN;
          n.phase     = sfbs_pkg::PH_GAP;
          n.div       = 8'h00;
          // every program or erase needs its own fresh write enable
          n.step = (I_CMD_OP == sfbs_pkg::OP_READ) ? sfbs_pkg::H_OP
                                                   : sfbs_pkg::H_WRITE_ENABLE_CMD;
        end
      end
      // deselect time between commands
      sfbs_pkg::PH_GAP:
      begin
        n.div = r.div + 8'h01;
        if (r.div == sfbs_pkg::CS_GAP_CYC - 8'h01)
        begin
          n.div   = 8'h00;
          n.k     = 25'h0000000;
          n.phase = sfbs_pkg::PH_LOAD;
        end
      end
      // start a byte, waiting for program data or buffer room
      sfbs_pkg::PH_LOAD:
      begin
        if (in_data & wr_data & ~(r.wr_ready & I_WR_VALID))
        begin
          n.wr_ready = 1'b1;
        end
        else if (in_data & rd_data & (~fill_if.ready | r.push))
        begin
          // a push in flight is not yet in ready; clock stays low, flash waits
          n.wr_ready = 1'b0;
        end
        else
        begin
          n.wr_ready = 1'b0;
          n.tx       = tx_byte;
          n.mosi     = tx_byte[7];
          n.cs0_n    = r.sel;
          n.cs1_n    = ~r.sel;
          n.bitn     = 3'h0;
          n.div      = 8'h00;
          n.phase    = sfbs_pkg::PH_SHIFT;
        end
      end
      // shift eight bits, msb first, mode 0
      sfbs_pkg::PH_SHIFT:
      begin
        n.div = r.div + 8'h01;
        if (r.div == half - 8'h01)
        begin
          n.div = 8'h00;
          if (~r.sck)
          begin
            n.sck = 1'b1;
            n.rx  = {r.rx[6:0], I_SPI_MISO};
          end
          else
          begin
            n.sck  = 1'b0;
            n.tx   = {r.tx[6:0], 1'b0};
            n.mosi = r.tx[6];
            n.bitn = r.bitn + 3'h1;
            if (r.bitn == 3'h7)
            begin
              // byte complete
              n.k     = r.k + 25'h0000001;
              n.phase = sfbs_pkg::PH_LOAD;
              if (in_data & rd_data)
              begin
                n.push  = 1'b1;
                n.pdata = r.rx;
              end
              if (last)
              begin
                n.cs0_n = 1'b1;
                n.cs1_n = 1'b1;
                n.mosi  = 1'b0;
                n.phase = sfbs_pkg::PH_GAP;
                if (r.k == 25'h0000001)
                begin
                  n.status = r.rx;
                end
                case (r.step)
                  sfbs_pkg::B_WRITE_ENABLE_CMD: n.step = sfbs_pkg::B_WEL;
                  // write status only once the latch reads set
                  sfbs_pkg::B_WEL:
                  begin
                    n.step = r.rx[sfbs_pkg::WRITE_LATCH_BIT] ? sfbs_pkg::B_WRITE_STATUS_CMD
                                                             : sfbs_pkg::B_WEL;
                  end
                  sfbs_pkg::B_WRITE_STATUS_CMD: n.step = sfbs_pkg::B_WIP;
                  // protection cleared: switch to the fast clock
                  sfbs_pkg::B_WIP:
                  begin
                    if (~r.rx[sfbs_pkg::FLASH_BUSY_FLAG])
                    begin
                      n.step = sfbs_pkg::B_READ;
                      n.fast = 1'b1;
                      n.sel  = 1'b0;
                      n.op   = sfbs_pkg::OP_READ;
                      n.addr = BOOT_ADDR;
                      n.len  = BOOT_LEN;
                    end
                  end
                  // image copied: hand over to initialization
                  sfbs_pkg::B_READ:
                  begin
                    n.step      = sfbs_pkg::H_IDLE;
                    n.boot_done = 1'b1;
                    n.cmd_ready = 1'b1;
                    n.phase     = sfbs_pkg::PH_IDLE;
                  end
                  sfbs_pkg::H_WRITE_ENABLE_CMD: n.step = sfbs_pkg::H_WEL;
                  sfbs_pkg::H_WEL:
                  begin
                    n.step = r.rx[sfbs_pkg::WRITE_LATCH_BIT] ? sfbs_pkg::H_OP
                                                             : sfbs_pkg::H_WEL;
                  end
                  sfbs_pkg::H_OP:
                  begin
                    if (r.op == sfbs_pkg::OP_READ)
                    begin
                      n.step      = sfbs_pkg::H_IDLE;
                      n.cmd_ready = 1'b1;
                      n.phase     = sfbs_pkg::PH_IDLE;
                    end
                    else
                    begin
                      n.step = sfbs_pkg::H_WIP;
                    end
                  end
                  // no new command until the flash is no longer busy
                  sfbs_pkg::H_WIP:
                  begin
                    if (~r.rx[sfbs_pkg::FLASH_BUSY_FLAG])
                    begin
                      n.step      = sfbs_pkg::H_IDLE;
                      n.cmd_ready = 1'b1;
                      n.phase     = sfbs_pkg::PH_IDLE;
                    end
                  end
                  default: n.step = sfbs_pkg::H_IDLE;
                endcase
              end
            end
          end
        end
      end
      default: n.phase = sfbs_pkg::PH_IDLE;
    endcase
  end

  // state register; synchronous reset restarts the boot flow
  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      r <= sfbs_pkg::SEQ_RESET;
    end
    else
    begin
      r <= n;
    end
  end

  // outputs straight from flops
  assign O_SPI_SCK             = r.sck;
  assign O_SPI_MOSI            = r.mosi;
  assign O_BOOT_FLASH_SELECT_N = r.cs0_n;
  assign O_AUX_FLASH_SELECT_N  = r.cs1_n;
  assign O_BOOT_DONE           = r.boot_done;
  assign O_FAST_CLK            = r.fast;
  assign O_STATUS              = r.status;
  assign O_CMD_READY           = r.cmd_ready;
  assign O_WR_READY            = r.wr_ready;
  assign O_RD_DATA             = drain_if.data;
  assign O_RD_VALID            = drain_if.valid;

endmodule : sfbs_sequencer
`default_nettype wire

// file: test/sfbs_chk.sv
// checker: serial pin and handshake assertions of the boot sequencer
`timescale 1ns/1ps
`default_nettype none
module sfbs_chk (
  input wire logic       I_CLK_SYS,
  input wire logic       I_RST,
  input wire logic       O_SPI_SCK,
  input wire logic       O_SPI_MOSI,
  input wire logic       O_BOOT_FLASH_SELECT_N,
  input wire logic       O_AUX_FLASH_SELECT_N,
  input wire logic       O_BOOT_DONE,
  input wire logic       O_FAST_CLK,
  input wire logic       I_CMD_VALID,
  input wire logic       O_CMD_READY,
  input wire logic       I_WR_VALID,
  input wire logic       O_WR_READY,
  input wire logic [7:0] O_RD_DATA,
  input wire logic       O_RD_VALID,
  input wire logic       I_RD_READY
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_RST);
  logic [7:0] hi_ff;  // cycles the serial clock has stayed high
  logic [7:0] gap_ff; // cycles both selects high, saturating
  // helper counters; saturation keeps long idle from wrapping
  always_ff @(posedge I_CLK_SYS)
  begin
    hi_ff  <= (I_RST || !O_SPI_SCK) ? 8'h00 : hi_ff + 8'h01;
    gap_ff <= (I_RST || !(O_BOOT_FLASH_SELECT_N && O_AUX_FLASH_SELECT_N)) ? 8'h00 :
              ((gap_ff == 8'hFF) ? gap_ff : gap_ff + 8'h01);
  end
  sequence s_cmd_take;
    O_CMD_READY && I_CMD_VALID;
  endsequence
  sequence s_wr_take;
    O_WR_READY && I_WR_VALID;
  endsequence
  sck_idle_a: assert property ((O_BOOT_FLASH_SELECT_N && O_AUX_FLASH_SELECT_N) |-> !O_SPI_SCK)
    else $error("serial clock high while deselected");
  one_select_a: assert property (O_BOOT_FLASH_SELECT_N || O_AUX_FLASH_SELECT_N)
    else $error("both selects low");
  boot_select_a: assert property (!O_BOOT_DONE |-> O_AUX_FLASH_SELECT_N)
    else $error("aux select used during boot");
  mosi_hold_a: assert property (O_SPI_SCK |-> $stable(O_SPI_MOSI))
    else $error("data changed while clock high");
  // rate flag switches on the very edge that ends the last slow half
  sck_half_a: assert property ($fell(O_SPI_SCK) |->
    hi_ff == ($past(O_FAST_CLK) ? sfbs_pkg::FAST_HALF : sfbs_pkg::SLOW_HALF))
    else $error("serial clock high time wrong");
  boot_fast_a: assert property ($rose(O_BOOT_DONE) |-> O_FAST_CLK)
    else $error("boot finished on slow clock");
  cs_gap_a: assert property (($fell(O_BOOT_FLASH_SELECT_N) || $fell(O_AUX_FLASH_SELECT_N))
    |-> gap_ff >= sfbs_pkg::CS_GAP_CYC)
    else $error("deselect gap too short");
  cmd_take_a: assert property (s_cmd_take |=> !O_CMD_READY)
    else $error("command ready held after take");
  boot_ready_a: assert property (!O_BOOT_DONE |-> !O_CMD_READY)
    else $error("command ready before boot done");
  wr_take_a: assert property (s_wr_take |=> !O_WR_READY)
    else $error("write ready held after take");
  rd_hold_a: assert property ((O_RD_VALID && !I_RD_READY) |=> O_RD_VALID && $stable(O_RD_DATA))
    else $error("read data dropped while stalled");
  done_hold_a: assert property (O_BOOT_DONE |=> O_BOOT_DONE)
    else $error("boot done fell");
endmodule : sfbs_chk
bind sfbs_sequencer sfbs_chk i_sfbs_chk (
  .I_CLK_SYS(I_CLK_SYS), .I_RST(I_RST), .O_SPI_SCK(O_SPI_SCK), .O_SPI_MOSI(O_SPI_MOSI),
  .O_BOOT_FLASH_SELECT_N(O_BOOT_FLASH_SELECT_N), .O_AUX_FLASH_SELECT_N(O_AUX_FLASH_SELECT_N),
  .O_BOOT_DONE(O_BOOT_DONE), .O_FAST_CLK(O_FAST_CLK), .I_CMD_VALID(I_CMD_VALID),
  .O_CMD_READY(O_CMD_READY), .I_WR_VALID(I_WR_VALID), .O_WR_READY(O_WR_READY),
  .O_RD_DATA(O_RD_DATA), .O_RD_VALID(O_RD_VALID), .I_RD_READY(I_RD_READY));
`default_nettype wire

// file: test/sfbs_flash_model.sv
// partner: behavioural single-line serial flash, mode 0, counts protocol faults
`timescale 1ns/1ps
`default_nettype none
module sfbs_flash_model #(
  parameter logic [7:0] KEY  = 8'h5A, // content pattern key
  parameter int         LAG  = 1,     // status polls before latch shows
  parameter int         BUSY = 2      // status polls while busy
) (
  input  wire logic i_sck,
  input  wire logic i_mosi,
  input  wire logic i_cs_n,
  output logic      o_miso,
  output logic [7:0] o_prot,
  output int        o_err
);
  logic [7:0]  sh, ob, cmd;  // shift in, next byte out, opcode
  logic [23:0] a;            // running address
  logic        write_latch_bit;          // write latch
  int          bitc, bc, lag, busy;
  // protected by default, bit 7 set as write lock
  initial
  begin
    o_miso = 1'b0; o_prot = 8'hFC; o_err = 0; write_latch_bit = 1'b0;
    lag = 0; busy = 0; bitc = 0; bc = 0; ob = 8'h00; cmd = 8'h00; a = 24'h000000;
  end
  // frame start; clock must idle low
  always @(negedge i_cs_n)
  begin
    bitc = 0; bc = 0;
    if (i_sck) o_err++;
  end
  // command completes at deselect; released line toggles
  always @(posedge i_cs_n)
  begin
    o_miso = ~o_miso;
    if (bc > 0)
      case (cmd)
        8'h05: begin if (lag > 0) lag--; if (busy > 0) busy--; end
        8'h06: begin write_latch_bit = 1'b1; lag = LAG; end
        8'h01, 8'h02, 8'h20, 8'hC7:
        begin
          if (!write_latch_bit) o_err++;
          write_latch_bit = 1'b0; busy = BUSY;
        end
        default: ;
      endcase
  end
  // sample on rising edge, one data line
  always @(posedge i_sck) if (!i_cs_n)
  begin
    sh = {sh[6:0], i_mosi}; bitc++;
    if (bitc == 8)
    begin
      bitc = 0; ob = ~sh;
      if (bc == 0) begin cmd = sh; if (busy > 0 && sh != 8'h05) o_err++; end
      else if (bc < 4) a = {a[15:0], sh};
      if ((cmd == 8'h05 || cmd == 8'h01) && bc > 1) o_err++;
      if (cmd == 8'h05) ob = {o_prot[7:2], write_latch_bit && lag == 0, busy > 0};
      if (cmd == 8'h01 && bc == 1 && write_latch_bit) o_prot = sh;
      if (cmd == 8'h0B && bc >= 4) begin ob = a[7:0] ^ a[15:8] ^ KEY; a++; end
      if (cmd == 8'h02 && bc >= 4) begin if (sh !== (a[7:0] ^ a[15:8] ^ KEY)) o_err++; a++; end
      bc++;
    end
  end
  // drive on falling edge, msb first
  always @(negedge i_sck) if (!i_cs_n) o_miso = ob[7 - bitc];
endmodule : sfbs_flash_model
`default_nettype wire

// file: test/tb_sfbs_sequencer.sv
// testbench: boot, stalled read, program and erases against two flash models
`timescale 1ns/1ps
`default_nettype none
module tb_sfbs_sequencer;
  logic        clk = 1'b0, rst = 1'b1, sck, mosi, miso, cs0_n, cs1_n, m0, m1, done, fast;
  logic [7:0]  status, rd_data, prot0, prot1, wr_data = 8'h00;
  logic        cmd_valid = 1'b0, cmd_sel = 1'b0, cmd_ready, wr_valid = 1'b0, wr_ready;
  logic        rd_valid, rd_ready = 1'b0, stall = 1'b1;
  logic [1:0]  cmd_op = 2'h0;
  logic [23:0] cmd_addr = 24'h000000, cmd_len = 24'h000000, ra;
  logic [31:0] seed = 32'h3D8F;
  logic [7:0]  rq[$], wq[$]; // expected read bytes, program bytes
  int          num_errors = 0, n_tests = 0, err0, err1, n;
  assign miso = !cs0_n ? m0 : m1; // shared data line
  always #2 clk = ~clk;
  sfbs_sequencer #(.BOOT_ADDR(24'h000010), .BOOT_LEN(24'h000008), .FIFO_DEPTH(16))
  i_sfbs_sequencer (.I_CLK_SYS(clk), .I_RST(rst), .O_SPI_SCK(sck), .O_SPI_MOSI(mosi),
    .I_SPI_MISO(miso), .O_BOOT_FLASH_SELECT_N(cs0_n), .O_AUX_FLASH_SELECT_N(cs1_n),
    .O_BOOT_DONE(done), .O_FAST_CLK(fast), .O_STATUS(status), .I_CMD_VALID(cmd_valid),
    .I_CMD_OP(cmd_op), .I_CMD_SEL(cmd_sel), .I_CMD_ADDR(cmd_addr), .I_CMD_LEN(cmd_len),
    .O_CMD_READY(cmd_ready), .I_WR_DATA(wr_data), .I_WR_VALID(wr_valid),
    .O_WR_READY(wr_ready), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid), .I_RD_READY(rd_ready));
  sfbs_flash_model #(.KEY(8'h5A)) i_flash0 (.i_sck(sck), .i_mosi(mosi), .i_cs_n(cs0_n),
    .o_miso(m0), .o_prot(prot0), .o_err(err0));
  sfbs_flash_model #(.KEY(8'hC3)) i_flash1 (.i_sck(sck), .i_mosi(mosi), .i_cs_n(cs1_n),
    .o_miso(m1), .o_prot(prot1), .o_err(err1));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [7:0] pat(input logic [7:0] key, input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ key;
  endfunction : pat
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done();
    if (num_errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done
  // bounded wait for idle
  task automatic wait_ready();
    n = 0;
    while (cmd_ready !== 1'b1 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : wait_ready
  // one host command; extra edge lets ready fall first
  task automatic host_cmd(input logic [1:0] op, input logic sel, input logic [23:0] a, l);
    wait_ready();
    cmd_valid <= 1'b1; cmd_op <= op; cmd_sel <= sel; cmd_addr <= a; cmd_len <= l;
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(posedge clk);
  endtask : host_cmd
  // read side: random ready, compares oldest note
  always @(posedge clk)
  begin
    seed <= lfsr(seed);
    rd_ready <= !stall && seed[0];
    if (rd_valid && rd_ready)
    begin
      if (rq.size() == 0) chk("rd_extra", 8'h00, 8'hFF);
      else chk("rd_data", rq.pop_front(), rd_data);
    end
  end
  // program data feed, one byte per take
  always @(posedge clk)
  begin
    if (wr_valid && wr_ready)
    begin
      void'(wq.pop_front());
      wr_valid <= 1'b0;
    end
    else if (!wr_valid && wq.size() > 0)
    begin
      wr_valid <= 1'b1;
      wr_data  <= wq[0];
    end
  end
  initial
  begin
    for (int i = 0; i < 8; i++) rq.push_back(pat(8'h5A, 24'h000010 + 24'(i)));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 60000) begin @(posedge clk); n++; end
    @(posedge clk);
    chk("boot_done", 8'h01, {7'h00, done});
    chk("fast_clk", 8'h01, {7'h00, fast});
    chk("protection", 8'h00, prot0);
    // fifo fills and refuses while reader stalls
    ra = seed[23:0];
    for (int i = 0; i < 40; i++) rq.push_back(pat(8'hC3, ra + 24'(i)));
    host_cmd(sfbs_pkg::OP_READ, 1'b1, ra, 24'h000028);
    repeat (3000) @(posedge clk);
    stall <= 1'b0;
    for (int i = 0; i < 4; i++) wq.push_back(pat(8'h5A, 24'h000100 + 24'(i)));
    host_cmd(sfbs_pkg::OP_PROG, 1'b0, 24'h000100, 24'h000004);
    host_cmd(sfbs_pkg::OP_SERASE, 1'b1, 24'h003000, 24'h000000);
    host_cmd(sfbs_pkg::OP_CERASE, 1'b0, 24'h000000, 24'h000000);
    wait_ready();
    chk("status", 8'h00, status);
    chk("rd_left", 8'h00, 8'(rq.size()));
    chk("aux_protection", 8'hFC, prot1);
    chk("flash0_faults", 8'h00, 8'(err0));
    chk("flash1_faults", 8'h00, 8'(err1));
    test_done();
  end
  // watchdog against a hung sequence
  initial
  begin
    repeat (95000) @(posedge clk);
    num_errors++;
    test_done();
  end
endmodule : tb_sfbs_sequencer
`default_nettype wire
